// ==== tcp_pkg.sv ====
// constants, field layouts and carrier types of the capture and pulse unit
package tcp_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int          TCP_NCH        = 8;
    localparam int          TCP_CNT_W      = 16;
    localparam int          TCP_PSC_W      = 8;
    localparam int          TCP_ADDR_W     = 8;
    localparam int          TCP_GATE_CH0   = 6;
    localparam int          TCP_GATE_OFS   = 2;

    // ----------------------------------------------------------------
    // register byte offsets; per-channel blocks have a 4-byte stride
    // ----------------------------------------------------------------
    localparam logic [7:0]  OFS_BASE_CTL   = 8'h00;
    localparam logic [7:0]  OFS_BASE_CNT   = 8'h04;
    localparam logic [7:0]  OFS_FUNC_SEL   = 8'h08;
    localparam logic [7:0]  OFS_CH_EN      = 8'h0C;
    localparam logic [7:0]  OFS_CAP_IRQ    = 8'h10;
    localparam logic [7:0]  OFS_CMP_IRQ    = 8'h14;
    localparam logic [7:0]  OFS_PSC6       = 8'h18;
    localparam logic [7:0]  OFS_PSC7       = 8'h1C;
    localparam logic [7:0]  OFS_CAP_CTL    = 8'h20;
    localparam logic [7:0]  OFS_CAP_VAL    = 8'h40;
    localparam logic [7:0]  OFS_OUT_CTL    = 8'h60;
    localparam logic [7:0]  OFS_CMP_VAL    = 8'h80;

    // ----------------------------------------------------------------
    // field encodings
    // ----------------------------------------------------------------
    localparam logic [2:0]  MODE_SINGLE    = 3'h0;
    localparam logic [4:0]  DIV_NONE       = 5'h1F;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;
    localparam logic [7:0]  RST_BYTE       = 8'h00;
    localparam logic [15:0] RST_WORD       = 16'h0000;

    // base_control_reg layout
    typedef struct packed {
        logic [4:0] div;
        logic       reset_alt_bit;
        logic       reset_on_match_bit;
        logic       run;
    } tcp_base_ctl_t;

    // capture_control_reg layout; filt[1] enables, filt[0] picks base clock
    typedef struct packed {
        logic       gate_soft_clear_bit;
        logic       gate_match_clear_bit;
        logic       gate_enable_bit;
        logic       prescale_enable_bit;
        logic [1:0] filter_select_field;
        logic [1:0] trigger_edge_field;
    } tcp_cap_ctl_t;

    // output_control_reg layout
    typedef struct packed {
        logic [1:0] unused;
        logic       output_invert_bit;
        logic       reload_timing_bit;
        logic       default_level_bit;
        logic [2:0] output_mode_field;
    } tcp_out_ctl_t;

endpackage

// ==== tcp_trig_filt.sv ====
// trigger pin synchroniser, three-sample filter and edge detector
`timescale 1ns/100ps
module tcp_trig_filt (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // pin and control
    input  wire logic pin,
    input  wire logic filt_on,
    input  wire logic sample_en,
    // edge pulses
    output logic      rise,
    output logic      fall
);
    import tcp_pkg::*;

    logic       s1_r, s2_r, s3_r, sync_r, sync_nxt;
    logic [2:0] hist_r, hist_nxt;
    logic       flt_r, flt_nxt, prev_r, prev_nxt, rise_nxt, fall_nxt;
    logic       sel;

    always_comb begin
        sync_nxt = (s2_r == s3_r) ? s3_r : sync_r;
        hist_nxt = hist_r;
        flt_nxt  = flt_r;
        if (sample_en) begin
            hist_nxt = {hist_r[1:0], sync_r};
            // a level passes only after three equal samples
            if (hist_nxt == 3'h7 || hist_nxt == 3'h0) begin //R7
                flt_nxt = hist_nxt[0];
            end
        end
        sel      = filt_on ? flt_r : sync_r; //R23
        prev_nxt = sel;
        rise_nxt = sel & ~prev_r;
        fall_nxt = ~sel & prev_r;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_r   <= 1'b0;
            s2_r   <= 1'b0;
            s3_r   <= 1'b0;
            sync_r <= 1'b0;
            hist_r <= 3'h0;
            flt_r  <= 1'b0;
            prev_r <= 1'b0;
            rise   <= 1'b0;
            fall   <= 1'b0;
        end else begin
            s1_r   <= pin;
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            sync_r <= sync_nxt;
            hist_r <= hist_nxt;
            flt_r  <= flt_nxt;
            prev_r <= prev_nxt;
            rise   <= rise_nxt;
            fall   <= fall_nxt;
        end
    end
endmodule

// ==== tcp_base.sv ====
// base counter with clock divider and clear two ticks after channel 0 match
`timescale 1ns/100ps
module tcp_base (
    // clock and reset
    input  wire logic                           aclk,
    input  wire logic                           aresetn,
    // control
    input  wire tcp_pkg::tcp_base_ctl_t         ctl,
    input  wire logic [tcp_pkg::TCP_CNT_W-1:0]  cmp0,
    // count
    output logic [tcp_pkg::TCP_CNT_W-1:0]       cnt,
    output logic                                tick
);
    import tcp_pkg::*;

    logic [5:0]           dcnt_r, dcnt_nxt;
    logic [TCP_CNT_W-1:0] cnt_nxt;
    logic                 hit_r, hit_nxt, tick_nxt, clr_en;

    always_comb begin
        clr_en   = ctl.reset_on_match_bit & ~ctl.reset_alt_bit;
        dcnt_nxt = dcnt_r + 6'h01;
        tick_nxt = 1'b0;
        cnt_nxt  = cnt;
        hit_nxt  = hit_r;
        // divide by 2(div+1), or not at all for the top code
        if (ctl.div == DIV_NONE || dcnt_r == {ctl.div, 1'b1}) begin
            dcnt_nxt = 6'h00;
            tick_nxt = 1'b1;
        end
        if (!ctl.run) begin
            dcnt_nxt = 6'h00;
            tick_nxt = 1'b0;
            cnt_nxt  = RST_WORD;
            hit_nxt  = 1'b0;
        end else if (tick_nxt) begin
            cnt_nxt = cnt + 16'h0001;
            hit_nxt = 1'b0;
            if (hit_r) begin
                cnt_nxt = RST_WORD; //R22
            end else if (clr_en && cnt == cmp0) begin
                hit_nxt = 1'b1; //R22
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dcnt_r <= 6'h00;
            cnt    <= RST_WORD;
            hit_r  <= 1'b0;
            tick   <= 1'b0;
        end else begin
            dcnt_r <= dcnt_nxt;
            cnt    <= cnt_nxt;
            hit_r  <= hit_nxt;
            tick   <= tick_nxt;
        end
    end
endmodule

// ==== tcp_top.sv ====
// eight-channel capture and single-phase pulse unit with AXI4-Lite registers
//
// Overview of operation
// R1: each accepted trigger copies the base count into that channel's capture register
// R2: trigger edge per channel: rising, falling or both
// R3: capture runs while enable is 1 and function select is 1
// R4: clearing enable stops the channel's capture or waveform
// R5: channels 6, 7 with prescale capture once per prescale value plus one triggers
// R6: capture sets the channel's capture flag
// R7: filter passes a level after three equal samples, at aclk or base rate
// R8: gated channels 6, 7 ignore triggers after the first capture
// R9: gate reopens on soft clear write or, if enabled, on compare 4 or 5 match
// R10: software sets up the base timer before capture settings
// R11: compare mode drives outputs from base count equal to compare value
// R12: function select 0 means compare mode
// R13: reload bit picks immediate or at-zero compare reload
// R14: single-phase output rises on match, falls when count reaches zero
// R15: default level bit sets the starting output level on enable
// R16: inversion bit flips the final output level
// R17: free running the period is 65536 base clocks, low m, high 65536-m
// R18: cleared by channel 0 match, period n+2 clocks, low m
// R19: compare value at least n+2 keeps output low
// R20: base count equal to compare value sets the compare flag
// R21: mode field 000 selects single-phase output
// R22: base count clears two base clocks after matching channel 0
// R23: edges come from filtered signal when filtering, else synchronised pin
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
module tcp_top #(
    parameter int PSC_W = tcp_pkg::TCP_PSC_W
) (
    // clock and reset
    input  wire logic                           aclk,
    input  wire logic                           aresetn,
    // axi4-lite write address and data
    input  wire logic [tcp_pkg::TCP_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                           s_axi_awvalid,
    output logic                                s_axi_awready,
    input  wire logic [31:0]                    s_axi_wdata,
    input  wire logic [3:0]                     s_axi_wstrb,
    input  wire logic                           s_axi_wvalid,
    output logic                                s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                          s_axi_bresp,
    output logic                                s_axi_bvalid,
    input  wire logic                           s_axi_bready,
    // axi4-lite read
    input  wire logic [tcp_pkg::TCP_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                           s_axi_arvalid,
    output logic                                s_axi_arready,
    output logic [31:0]                         s_axi_rdata,
    output logic [1:0]                          s_axi_rresp,
    output logic                                s_axi_rvalid,
    input  wire logic                           s_axi_rready,
    // pins
    input  wire logic [tcp_pkg::TCP_NCH-1:0]    trigger_input_pin,
    output logic [tcp_pkg::TCP_NCH-1:0]         pulse_output_pin
);
    import tcp_pkg::*;

    // ----------------------------------------------------------------
    // bus handshake
    // ----------------------------------------------------------------
    logic                 wr_fire, rd_fire;
    logic [7:0]           wa, ra;
    logic [2:0]           wch;
    logic                 bvalid_nxt, rvalid_nxt;
    logic [1:0]           bresp_nxt, rresp_nxt;
    logic [31:0]          rdata_nxt;
    logic                 wmap, rmap;

    // address and data are taken together, so no half-write is ever parked
    assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    assign s_axi_wready  = s_axi_awready;
    assign s_axi_arready = ~s_axi_rvalid;
    assign wr_fire       = s_axi_awready;
    assign rd_fire       = s_axi_arvalid & s_axi_arready;
    assign wa            = s_axi_awaddr;
    assign ra            = s_axi_araddr;
    assign wch           = wa[4:2];

    // ----------------------------------------------------------------
    // shared registers
    // ----------------------------------------------------------------
    tcp_base_ctl_t        bctl_r, bctl_nxt;
    logic [TCP_NCH-1:0]   fs_r, fs_nxt, fe_r, fe_nxt, fe_d_r;
    logic [PSC_W-1:0]     psc_r [TCP_NCH];
    logic [PSC_W-1:0]     psc_nxt [TCP_NCH];
    logic [TCP_CNT_W-1:0] cnt;
    logic                 tick, zero_ev;
    logic [TCP_NCH-1:0]   rise, fall, cmp_eq, capf, cmpf, pin_nxt;
    logic [TCP_CNT_W-1:0] capv [TCP_NCH];
    logic [TCP_CNT_W-1:0] cmpbuf [TCP_NCH];
    logic [TCP_CNT_W-1:0] cmpact [TCP_NCH];
    tcp_cap_ctl_t         cc [TCP_NCH];
    tcp_out_ctl_t         oc [TCP_NCH];
    logic                 w_blk0;

    assign w_blk0  = wr_fire & s_axi_wstrb[0];
    assign zero_ev = tick & (cnt == RST_WORD);

    always_comb begin
        bctl_nxt = bctl_r;
        fs_nxt   = fs_r;
        fe_nxt   = fe_r;
        psc_nxt  = psc_r;
        if (w_blk0) begin
            unique case (wa)
                OFS_BASE_CTL: bctl_nxt = tcp_base_ctl_t'(s_axi_wdata[7:0]);
                OFS_FUNC_SEL: fs_nxt   = s_axi_wdata[TCP_NCH-1:0]; //R3 R12
                OFS_CH_EN:    fe_nxt   = s_axi_wdata[TCP_NCH-1:0]; //R3 R4
                OFS_PSC6:     psc_nxt[TCP_GATE_CH0]   = s_axi_wdata[PSC_W-1:0];
                OFS_PSC7:     psc_nxt[TCP_GATE_CH0+1] = s_axi_wdata[PSC_W-1:0];
                default:      bctl_nxt = bctl_r;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bctl_r <= tcp_base_ctl_t'(RST_BYTE);
            fs_r   <= RST_BYTE;
            fe_r   <= RST_BYTE;
            fe_d_r <= RST_BYTE;
            for (int i = 0; i < TCP_NCH; i++) begin
                psc_r[i] <= '0;
            end
        end else begin
            bctl_r <= bctl_nxt;
            fs_r   <= fs_nxt;
            fe_r   <= fe_nxt;
            fe_d_r <= fe_r;
            psc_r  <= psc_nxt;
        end
    end

    tcp_base u_base (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ctl     (bctl_r),
        .cmp0    (cmpact[0]),
        .cnt     (cnt),
        .tick    (tick)
    );

    // ----------------------------------------------------------------
    // channels
    // ----------------------------------------------------------------
    for (genvar j = 0; j < TCP_NCH; j++) begin : g_ch
        localparam bit EXT = (j >= TCP_GATE_CH0);
        localparam int GP  = EXT ? j - TCP_GATE_OFS : j;

        tcp_cap_ctl_t         cc_r, cc_nxt;
        tcp_out_ctl_t         oc_r, oc_nxt;
        logic [TCP_CNT_W-1:0] cv_r, cv_nxt, cb_r, cb_nxt, ca_r, ca_nxt;
        logic [PSC_W-1:0]     pc_r, pc_nxt;
        logic                 gate_r, gate_nxt, lvl_r, lvl_nxt;
        logic                 capf_r, capf_nxt, cmpf_r, cmpf_nxt;
        logic                 cap_w, out_w, cmp_w, gsc_w, trig, cap_now;
        logic                 use_psc, psc_hit, cap_on, cmp_on, wave_on, start;

        tcp_trig_filt u_filt (
            .aclk      (aclk),
            .aresetn   (aresetn),
            .pin       (trigger_input_pin[j]),
            .filt_on   (cc_r.filter_select_field[1]),
            .sample_en (cc_r.filter_select_field[0] ? tick : 1'b1),
            .rise      (rise[j]),
            .fall      (fall[j])
        );

        assign cap_w     = w_blk0 & (wa[7:5] == OFS_CAP_CTL[7:5]) & (wch == j);
        assign out_w     = w_blk0 & (wa[7:5] == OFS_OUT_CTL[7:5]) & (wch == j);
        assign cmp_w     = wr_fire & (wa[7:5] == OFS_CMP_VAL[7:5]) & (wch == j);
        assign gsc_w     = cap_w & s_axi_wdata[7];
        assign cap_on    = fe_r[j] & fs_r[j]; //R3 R4
        assign cmp_on    = fe_r[j] & ~fs_r[j]; //R12
        assign wave_on   = cmp_on & (oc_r.output_mode_field == MODE_SINGLE); //R21
        assign start     = fe_r[j] & ~fe_d_r[j] & ~fs_r[j];
        assign cmp_eq[j] = tick & (cnt == ca_r); //R11
        assign use_psc   = EXT & cc_r.prescale_enable_bit;
        assign psc_hit   = (pc_r == psc_r[j]);
        assign trig      = cap_on & ((cc_r.trigger_edge_field[0] & rise[j])
                                   | (cc_r.trigger_edge_field[1] & fall[j])); //R2
        assign cap_now   = trig & ~gate_r & (~use_psc | psc_hit); //R5 R8

        always_comb begin
            cc_nxt   = cc_r;
            oc_nxt   = oc_r;
            cv_nxt   = cv_r;
            cb_nxt   = cb_r;
            ca_nxt   = ca_r;
            pc_nxt   = pc_r;
            gate_nxt = gate_r;
            lvl_nxt  = lvl_r;
            if (cap_w) begin
                cc_nxt = tcp_cap_ctl_t'(s_axi_wdata[7:0]);
                if (!EXT) begin
                    cc_nxt.gate_enable_bit      = 1'b0;
                    cc_nxt.gate_match_clear_bit = 1'b0;
                    cc_nxt.prescale_enable_bit  = 1'b0;
                end
            end
            cc_nxt.gate_soft_clear_bit = 1'b0;
            if (out_w) begin
                oc_nxt = tcp_out_ctl_t'(s_axi_wdata[7:0]);
                oc_nxt.unused = 2'h0;
            end
            if (cmp_w) begin
                if (s_axi_wstrb[0]) cb_nxt[7:0]  = s_axi_wdata[7:0];
                if (s_axi_wstrb[1]) cb_nxt[15:8] = s_axi_wdata[15:8];
            end
            // capture path
            if (cap_now) begin
                cv_nxt = cnt; //R1
            end
            if (!use_psc || !cap_on) begin
                pc_nxt = '0;
            end else if (trig && !gate_r) begin
                pc_nxt = psc_hit ? '0 : pc_r + 1'b1; //R5
            end
            if (!EXT || !cc_r.gate_enable_bit) begin
                gate_nxt = 1'b0;
            end else if (gate_r && (gsc_w || (cc_r.gate_match_clear_bit && cmp_eq[GP]))) begin
                gate_nxt = 1'b0; //R9
                cc_nxt.gate_match_clear_bit = 1'b0;
            end else if (cap_now) begin
                gate_nxt = 1'b1; //R8
            end
            // compare reload: immediate, or at the count's return to zero
            if (!oc_nxt.reload_timing_bit) begin
                ca_nxt = cb_nxt; //R13
            end else if (zero_ev) begin
                ca_nxt = cb_r; //R13
            end
            // single-phase level; match outranks zero so m=0 stays high
            if (start) begin
                lvl_nxt = oc_r.default_level_bit; //R15
            end else if (wave_on && cmp_eq[j]) begin
                lvl_nxt = 1'b1; //R14 R17 R18
            end else if (wave_on && zero_ev) begin
                lvl_nxt = 1'b0; //R14 R19
            end
            // hardware set outranks the software clear
            capf_nxt = cap_now | (capf_r & ~(w_blk0 & (wa == OFS_CAP_IRQ) & s_axi_wdata[j])); //R6
            cmpf_nxt = (cmp_on & cmp_eq[j])
                     | (cmpf_r & ~(w_blk0 & (wa == OFS_CMP_IRQ) & s_axi_wdata[j])); //R20
            pin_nxt[j] = wave_on & (lvl_r ^ oc_r.output_invert_bit); //R16 R4
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                cc_r   <= tcp_cap_ctl_t'(RST_BYTE);
                oc_r   <= tcp_out_ctl_t'(RST_BYTE);
                cv_r   <= RST_WORD;
                cb_r   <= RST_WORD;
                ca_r   <= RST_WORD;
                pc_r   <= '0;
                gate_r <= 1'b0;
                lvl_r  <= 1'b0;
                capf_r <= 1'b0;
                cmpf_r <= 1'b0;
                pulse_output_pin[j] <= 1'b0;
            end else begin
                cc_r   <= cc_nxt;
                oc_r   <= oc_nxt;
                cv_r   <= cv_nxt;
                cb_r   <= cb_nxt;
                ca_r   <= ca_nxt;
                pc_r   <= pc_nxt;
                gate_r <= gate_nxt;
                lvl_r  <= lvl_nxt;
                capf_r <= capf_nxt;
                cmpf_r <= cmpf_nxt;
                pulse_output_pin[j] <= pin_nxt[j];
            end
        end

        assign cc[j]     = cc_r;
        assign oc[j]     = oc_r;
        assign capv[j]   = cv_r;
        assign cmpbuf[j] = cb_r;
        assign cmpact[j] = ca_r;
        assign capf[j]   = capf_r;
        assign cmpf[j]   = cmpf_r;
    end

    // ----------------------------------------------------------------
    // bus answers
    // ----------------------------------------------------------------
    always_comb begin
        wmap = (wa[1:0] == 2'h0) & ((wa[7:5] != 3'h0) ? (wa[7:5] <= OFS_CMP_VAL[7:5])
                                                    : (wa != OFS_BASE_CNT));
        rmap = (ra[1:0] == 2'h0) & (ra[7:5] <= OFS_CMP_VAL[7:5]);
        rdata_nxt = s_axi_rdata;
        rresp_nxt = s_axi_rresp;
        rvalid_nxt = s_axi_rvalid & ~s_axi_rready;
        if (rd_fire) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = rmap ? RESP_OKAY : RESP_SLVERR;
            rdata_nxt  = 32'h00000000;
            unique case (ra[7:5])
                OFS_CAP_CTL[7:5]: rdata_nxt[7:0]  = cc[ra[4:2]];
                OFS_CAP_VAL[7:5]: rdata_nxt[15:0] = capv[ra[4:2]];
                OFS_OUT_CTL[7:5]: rdata_nxt[7:0]  = oc[ra[4:2]];
                OFS_CMP_VAL[7:5]: rdata_nxt[15:0] = cmpbuf[ra[4:2]];
                3'h0: begin
                    unique case (ra)
                        OFS_BASE_CTL: rdata_nxt[7:0]  = bctl_r;
                        OFS_BASE_CNT: rdata_nxt[15:0] = cnt;
                        OFS_FUNC_SEL: rdata_nxt[7:0]  = fs_r;
                        OFS_CH_EN:    rdata_nxt[7:0]  = fe_r;
                        OFS_CAP_IRQ:  rdata_nxt[7:0]  = capf;
                        OFS_CMP_IRQ:  rdata_nxt[7:0]  = cmpf;
                        OFS_PSC6:     rdata_nxt[PSC_W-1:0] = psc_r[TCP_GATE_CH0];
                        OFS_PSC7:     rdata_nxt[PSC_W-1:0] = psc_r[TCP_GATE_CH0+1];
                        default:      rdata_nxt = 32'h00000000;
                    endcase
                end
                default: rdata_nxt = 32'h00000000;
            endcase
            if (!rmap) rdata_nxt = 32'h00000000;
        end
        bresp_nxt  = s_axi_bresp;
        bvalid_nxt = s_axi_bvalid & ~s_axi_bready;
        if (wr_fire) begin
            bvalid_nxt = 1'b1;
            bresp_nxt  = wmap ? RESP_OKAY : RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= RESP_OKAY;
            s_axi_rdata  <= 32'h00000000;
        end else begin
            s_axi_bvalid <= bvalid_nxt;
            s_axi_bresp  <= bresp_nxt;
            s_axi_rvalid <= rvalid_nxt;
            s_axi_rresp  <= rresp_nxt;
            s_axi_rdata  <= rdata_nxt;
        end
    end
endmodule

// ==== tcp_props.sv ====
// bus handshake checker of the capture unit
`timescale 1ns/100ps
module tcp_props (
    input wire logic        aclk, aresetn,
    input wire logic        s_axi_awvalid, s_axi_wvalid,
    input wire logic        s_axi_awready, s_axi_wready,
    input wire logic        s_axi_bvalid, s_axi_bready,
    input wire logic [1:0]  s_axi_bresp, s_axi_rresp,
    input wire logic        s_axi_arvalid, s_axi_arready,
    input wire logic        s_axi_rvalid, s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_take; s_axi_awvalid && s_axi_wvalid && s_axi_awready; endsequence
    sequence rd_take; s_axi_arvalid && s_axi_arready; endsequence
    a_wr_answer: assert property (wr_take |=> s_axi_bvalid) else $error("no write answer");
    a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_wr_ready: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("bad awready");
    a_rd_answer: assert property (rd_take |=> s_axi_rvalid) else $error("no read answer");
    a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    a_rd_ready: assert property (s_axi_arready == !s_axi_rvalid) else $error("bad arready");
    a_rd_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
    a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
        else $error("error read with data");
endmodule

// ==== tcp_trig_src.sv ====
// trigger source model: replays the wanted levels some cycles late
`timescale 1ns/100ps
module tcp_trig_src (
    input  wire logic       aclk,
    input  wire logic [7:0] lvl,
    input  wire logic [3:0] lag,
    output logic [7:0]      pin
);
    logic [15:0][7:0] hist_r;
    always_ff @(posedge aclk) begin
        hist_r <= {hist_r[14:0], lvl};
        pin    <= hist_r[lag];
    end
endmodule

// ==== tcp_top_bench.sv ====
// self-checking bench of the capture and pulse unit
`timescale 1ns/100ps
module tcp_top_bench;
    import tcp_pkg::*;
    logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0, lvl = '0, trigger_input_pin, pulse_output_pin;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, d, c1;
    logic [3:0]  s_axi_wstrb = 4'hF, lag = '0;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    int          bad_count = 0, check_count = 0, w, n, m, hi, lo;
    always #5 aclk = ~aclk;
    tcp_top tcp_top_i (.*);
    tcp_trig_src tcp_trig_src_i (.aclk, .lvl, .lag, .pin(trigger_input_pin));
    task automatic chk(input string nm, input logic [31:0] got, exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do @(negedge aclk); while (!s_axi_awready);
        @(posedge aclk);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
        s_axi_bready  <= 1'b1;
        do @(negedge aclk); while (!s_axi_bvalid);
        resp = s_axi_bresp;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do @(negedge aclk); while (!s_axi_arready);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        s_axi_rready  <= 1'b1;
        do @(negedge aclk); while (!s_axi_rvalid);
        d    = s_axi_rdata;
        resp = s_axi_rresp;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask
    // pulse width is what the captures must measure
    task automatic pulse(input logic [7:0] b, input int wid);
        lvl <= b;
        repeat (wid) @(posedge aclk);
        lvl <= 8'h00;
        repeat (40) @(posedge aclk);
    endtask
    task automatic stop_test();
        if (bad_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #200us;
        bad_count++;
        stop_test();
    end
    initial begin
        void'($urandom(91));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFS_CH_EN);
        chk("en_reset", d, 32'h0);
        rd(8'hFC);
        chk("unmapped", resp, RESP_SLVERR);
        wr(OFS_BASE_CNT, 32'h1);
        chk("ro_write", resp, RESP_SLVERR);
        wr(OFS_BASE_CTL, 32'hF9);
        wr(OFS_CAP_CTL, 32'h1);
        wr(OFS_CAP_CTL + 4, 32'h2);
        wr(OFS_CAP_CTL + 8, 32'h3);
        wr(OFS_FUNC_SEL, 32'hCF);
        wr(OFS_CH_EN, 32'hCF);
        w = $urandom_range(60, 20);
        lag <= 4'($urandom_range(9, 0));
        pulse(8'h0F, w);
        rd(OFS_CAP_IRQ);
        chk("cap_flags", d, 32'h07);
        rd(OFS_CAP_VAL);
        c1 = d;
        rd(OFS_CAP_VAL + 4);
        chk("width", 16'(d - c1), w);
        rd(OFS_CAP_VAL + 8);
        chk("both_edges", d, c1 + w);
        wr(OFS_CAP_IRQ, 32'hFF);
        wr(OFS_CH_EN, 32'hCE);
        pulse(8'h0F, w);
        rd(OFS_CAP_IRQ);
        chk("stopped", d, 32'h06);
        wr(OFS_CAP_CTL + 4, 32'h0A);
        for (int k = 2; k <= 3; k++) begin
            wr(OFS_CAP_IRQ, 32'hFF);
            pulse(8'h02, k);
            rd(OFS_CAP_IRQ);
            chk("filter", d[1], k == 3);
        end
        wr(OFS_PSC6, 32'h2);
        wr(OFS_CAP_CTL + 24, 32'h11);
        wr(OFS_CAP_CTL + 28, 32'h21);
        wr(OFS_CAP_IRQ, 32'hFF);
        for (int k = 1; k <= 3; k++) begin
            pulse(8'hC0, w);
            rd(OFS_CAP_IRQ);
            chk("psc_gate", d[7:6], {1'b1, k == 3});
            if (k == 1) rd(OFS_CAP_VAL + 28);
            if (k == 1) c1 = d;
        end
        rd(OFS_CAP_VAL + 28);
        chk("gated", d, c1);
        wr(OFS_CAP_CTL + 28, 32'hA1);
        pulse(8'h80, w);
        rd(OFS_CAP_VAL + 28);
        chk("reopen", d, c1 + 3 * (w + 40) + 12);
        n = $urandom_range(80, 20);
        m = $urandom_range(n, 2);
        wr(OFS_CMP_VAL, n);
        wr(OFS_CMP_VAL + 16, m);
        wr(OFS_CMP_VAL + 20, m);
        wr(OFS_CMP_VAL + 12, n + 2);
        wr(OFS_OUT_CTL + 20, 32'h20);
        wr(OFS_FUNC_SEL, 32'h0);
        wr(OFS_CMP_IRQ, 32'hFF);
        wr(OFS_BASE_CTL, 32'h0);
        wr(OFS_BASE_CTL, 32'hFB);
        wr(OFS_CH_EN, 32'h39);
        @(posedge pulse_output_pin[4]);
        @(posedge aclk);
        while (pulse_output_pin[4]) begin hi++; @(posedge aclk); end
        while (!pulse_output_pin[4]) begin lo++; @(posedge aclk); end
        chk("high_width", hi, n + 2 - m);
        chk("low_width", lo, m);
        chk("inverted", pulse_output_pin[5], !pulse_output_pin[4]);
        chk("fixed_low", pulse_output_pin[3], 1'b0);
        rd(OFS_CMP_IRQ);
        chk("cmp_flags", d, 32'h31);
        stop_test();
    end
endmodule
bind tcp_top tcp_props tcp_props_i (.*);
